// [flash_prot_pkg.sv]
package flash_prot_pkg;
  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int FLASH_BYTES = 131072;
  localparam int BLOCK_BYTES = 1024;
  localparam int UNIT_BLOCKS = 2;
  localparam int WORD_BYTES = 4;
  localparam int NUM_BLOCKS = FLASH_BYTES / BLOCK_BYTES;
  localparam int NUM_UNITS = NUM_BLOCKS / UNIT_BLOCKS;
  localparam int WORDS = FLASH_BYTES / WORD_BYTES;
  localparam int BLOCK_WORDS = BLOCK_BYTES / WORD_BYTES;
  localparam int ADDR_W = $clog2(WORDS);
  localparam int BLK_W = $clog2(NUM_BLOCKS);
  localparam int UNIT_W = $clog2(NUM_UNITS);
  localparam int OFS_W = $clog2(BLOCK_WORDS);
  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic [31:0] ERASED_WORD = 32'hFFFFFFFF;
  localparam logic [1:0] PROT_RESET = 2'h0;
  localparam logic [1:0] SRC_FETCH = 2'h0;
  localparam logic [1:0] SRC_DATA = 2'h1;
  localparam logic [1:0] SRC_DEBUG = 2'h2;
  typedef enum logic [1:0] {
    OP_READ,
    OP_PROGRAM,
    OP_ERASE
  } op_t;
endpackage

// [flash_array_mem.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Flash word store with registered read data
// ------------------------------------------------------------------
module flash_array_mem #(
  parameter int DEPTH = 32768,
  parameter int AW = 15
) (
  input wire logic i_sys_clk,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [31:0] i_wdata,
  input wire logic i_re,
  input wire logic [AW-1:0] i_raddr,
  output logic [31:0] o_rdata
);
  logic [31:0] mem [DEPTH];
  logic [31:0] rdata_q;

  // Elaboration check: every word needs an address
  if (DEPTH > (1 << AW)) begin : g_depth_bad
    $error("flash_array_mem: depth exceeds address width");
  end

  // Write first in the process so a write and a read never race
  always_ff @(posedge i_sys_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    // Read data lasts one cycle, then clears, so no stale word lingers
    if (i_re) begin
      rdata_q <= mem[i_raddr];
    end else begin
      rdata_q <= '0;
    end
  end

  assign o_rdata = rdata_q;
endmodule

// [flash_block_protection.sv]
`timescale 1ns/1ps
module flash_block_protection #(
  parameter int NUM_UNITS = flash_prot_pkg::NUM_UNITS
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_req,
  input wire logic [1:0] i_op,
  input wire logic [1:0] i_src,
  input wire logic [flash_prot_pkg::ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic [NUM_UNITS-1:0] i_ro,
  input wire logic [NUM_UNITS-1:0] i_xo,
  output logic o_done,
  output logic [31:0] o_rdata,
  output logic o_err,
  output logic o_busy
);
  localparam int AW = flash_prot_pkg::ADDR_W;
  localparam int OW = flash_prot_pkg::OFS_W;
  localparam int BW = flash_prot_pkg::BLK_W;
  localparam int UW = flash_prot_pkg::UNIT_W;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // One mark per unit; the lookup indexes the marks by address bits
  if (NUM_UNITS != flash_prot_pkg::NUM_UNITS) begin : g_units_bad
    $error("flash_block_protection: unit count must match geometry");
  end
  // The sweep counter must wrap exactly at the end of a block
  if (flash_prot_pkg::BLOCK_WORDS != (1 << OW)) begin : g_block_bad
    $error("flash_block_protection: block must be a power of two");
  end
  // The block field must be one bit wider than the unit field, so a unit pairs two blocks
  if (BW != UW + 1) begin : g_pair_bad
    $error("flash_block_protection: a unit must pair two blocks");
  end

  // Idle, or sweeping the words of one block to the erased value
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ERASE
  } state_t;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  state_t state_q, state_d;
  logic busy_q, busy_d;
  logic [OW-1:0] ecnt_q, ecnt_d;
  logic [BW-1:0] eblk_q, eblk_d;
  logic done_q, done_d;
  logic err_q, err_d;

  // ----------------------------------------------------------------
  // Protection lookup and request decode
  // ----------------------------------------------------------------
  logic [UW-1:0] unit;
  logic unit_ro, unit_xo, wr_locked, rd_denied;
  logic take, op_read, op_prog, op_erase;
  logic rd_ok, prog_ok, erase_ok, refused;
  assign unit = i_addr[AW-1 -: UW];
  assign unit_ro = i_ro[unit];
  assign unit_xo = i_xo[unit];
  // Either mark freezes the unit's contents
  assign wr_locked = unit_ro | unit_xo;
  // Only the fetch path may see execute-only words
  assign rd_denied = unit_xo & (i_src != flash_prot_pkg::SRC_FETCH);
  // Requests that arrive during a sweep are dropped, not queued
  assign take = i_req & ~busy_q;
  assign op_read = take & (i_op == flash_prot_pkg::OP_READ);
  assign op_prog = take & (i_op == flash_prot_pkg::OP_PROGRAM);
  assign op_erase = take & (i_op == flash_prot_pkg::OP_ERASE);
  assign rd_ok = op_read & ~rd_denied;
  assign prog_ok = op_prog & ~wr_locked;
  assign erase_ok = op_erase & ~wr_locked;
  // Op code 3 is neither allowed nor refused: it just completes
  assign refused = (op_read & rd_denied) |
                   ((op_prog | op_erase) & wr_locked);

  // ----------------------------------------------------------------
  // Array port steering
  // ----------------------------------------------------------------
  logic mem_we, mem_re;
  logic [AW-1:0] mem_waddr;
  logic [31:0] mem_wdata, mem_rdata;

  // Erase sweeps the block word by word writing ones; a real cell
  // would erase in bulk, this trades time for a plain array.
  always_comb begin
    mem_we = prog_ok;
    mem_waddr = i_addr;
    mem_wdata = i_wdata;
    if (state_q == ST_ERASE) begin
      mem_we = 1'b1;
      mem_waddr = {eblk_q, ecnt_q};
      mem_wdata = flash_prot_pkg::ERASED_WORD;
    end
  end
  // Denied reads never touch the array, so its register stays zero
  assign mem_re = rd_ok;

  flash_array_mem #(
    .DEPTH(flash_prot_pkg::WORDS),
    .AW(AW)
  ) u_array (
    .i_sys_clk(i_sys_clk),
    .i_we(mem_we),
    .i_waddr(mem_waddr),
    .i_wdata(mem_wdata),
    .i_re(mem_re),
    .i_raddr(i_addr),
    .o_rdata(mem_rdata)
  );

  // ----------------------------------------------------------------
  // Control state
  // ----------------------------------------------------------------
  logic sweep_last;
  // Last word of the block is written on this edge
  assign sweep_last = (state_q == ST_ERASE) & (&ecnt_q);

  always_comb begin
    state_d = state_q;
    busy_d = busy_q;
    case (state_q)
      ST_IDLE: begin
        if (erase_ok) begin
          state_d = ST_ERASE;
          busy_d = 1'b1;
        end
      end
      ST_ERASE: begin
        if (sweep_last) begin
          state_d = ST_IDLE;
          busy_d = 1'b0;
        end
      end
      default: begin
        state_d = ST_IDLE;
        busy_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= ST_IDLE;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      busy_q <= busy_d;
    end
  end

  // ----------------------------------------------------------------
  // Erase sweep address
  // ----------------------------------------------------------------
  // The block is latched at the start, since the master may move its
  // address lines as soon as the request has been taken
  always_comb begin
    ecnt_d = ecnt_q;
    eblk_d = eblk_q;
    if (erase_ok) begin
      eblk_d = i_addr[AW-1 -: BW];
      ecnt_d = '0;
    end else if (state_q == ST_ERASE) begin
      ecnt_d = ecnt_q + 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      ecnt_q <= '0;
      eblk_q <= '0;
    end else begin
      ecnt_q <= ecnt_d;
      eblk_q <= eblk_d;
    end
  end

  // ----------------------------------------------------------------
  // Completion and error status
  // ----------------------------------------------------------------
  // Every taken request ends in one done pulse; an erase only after
  // its last word, so software cannot read a half-wiped block
  always_comb begin
    done_d = 1'b0;
    err_d = 1'b0;
    if (take && !erase_ok) begin
      done_d = 1'b1;
      err_d = refused;
    end else if (sweep_last) begin
      done_d = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      done_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      done_q <= done_d;
      err_q <= err_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_done = done_q;
  assign o_err = err_q;
  assign o_busy = busy_q;
  // The array's read register clears itself outside permitted reads
  assign o_rdata = mem_rdata;
endmodule

// [flash_prot_chk.sv]
`timescale 1ns/1ps
// Protection and timing watch on the flash access port
module flash_prot_chk #(
  parameter int NUM_UNITS = 64
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_req,
  input wire logic [1:0] i_op,
  input wire logic [1:0] i_src,
  input wire logic [flash_prot_pkg::ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic [NUM_UNITS-1:0] i_ro,
  input wire logic [NUM_UNITS-1:0] i_xo,
  input wire logic o_done,
  input wire logic [31:0] o_rdata,
  input wire logic o_err,
  input wire logic o_busy
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // Requests during an erase are dropped, so only idle ones count
  wire logic take = i_req && !o_busy;
  wire logic xo = i_xo[i_addr[14:9]];
  wire logic prot = i_ro[i_addr[14:9]] || xo;
  rd_one_cycle_a: assert property (
    take && i_op == 2'h0 |=> o_done) else $error("read late");
  err_has_done_a: assert property (
    o_err |-> o_done) else $error("error without done");
  write_refused_a: assert property (
    take && i_op inside {2'h1, 2'h2} && prot |=> o_err && !o_busy)
    else $error("protected write went ahead");
  erase_starts_a: assert property (
    take && i_op == 2'h2 && !prot |=> o_busy [*4])
    else $error("erase did not start");
  erase_len_a: assert property (
    $rose(o_busy) |-> ##256 (o_done && !o_busy))
    else $error("erase length wrong");
  xo_deny_a: assert property (
    take && i_op == 2'h0 && i_src != 2'h0 && xo |=> o_err && o_rdata == '0)
    else $error("exec-only data leaked");
  read_ok_a: assert property (
    take && i_op == 2'h0 && (i_src == 2'h0 || !xo) |=> !o_err)
    else $error("allowed read refused");
  busy_quiet_a: assert property (
    o_busy |-> !o_done && !o_err) else $error("done during erase");
  undef_quiet_a: assert property (
    take && i_op == 2'h3 |=> o_done && !o_err)
    else $error("undefined op flagged");
  rdata_idle_a: assert property (
    !o_done |-> o_rdata == '0) else $error("read data outside done");
  cover property (take && i_op == 2'h2 && !prot);
  cover property (o_err);
  cover property (take && i_op == 2'h0 && i_src == 2'h0 && xo);
endmodule
bind flash_block_protection flash_prot_chk #(.NUM_UNITS(NUM_UNITS)) u_chk (
  .i_sys_clk, .i_rst, .i_req, .i_op, .i_src, .i_addr, .i_wdata, .i_ro,
  .i_xo, .o_done, .o_rdata, .o_err, .o_busy);

// [flash_master_model.sv]
`timescale 1ns/1ps
// Stands in for fetch, data and debug masters
module flash_master_model (
  input wire logic i_sys_clk,
  input wire logic i_done,
  input wire logic i_err,
  input wire logic [31:0] i_rdata,
  output logic o_req = 1'b0,
  output logic [1:0] o_op = 2'h0,
  output logic [1:0] o_src = 2'h0,
  output logic [14:0] o_addr = 15'h0,
  output logic [31:0] o_wdata = 32'h0
);
  // One request pulse, then a bounded wait for its answer
  task automatic xfer(input logic [1:0] op, s, input logic [14:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    int n;
    @(negedge i_sys_clk);
    {o_op, o_src, o_addr, o_wdata, o_req} = {op, s, a, d, 1'b1};
    @(negedge i_sys_clk);
    o_req = 1'b0;
    // Released address and data lines carry junk so stale values never help the design
    o_addr = ~a;
    o_wdata = ~d;
    n = 0;
    while (i_done !== 1'b1 && n < 300) begin
      @(negedge i_sys_clk);
      n++;
    end
    q = i_rdata;
    e = (i_done === 1'b1) ? i_err : 1'bx;
  endtask
endmodule

// [tb_top.sv]
`timescale 1ns/1ps
`define CHK(n, x, y) begin num_checks++; if ((y) !== (x)) begin \
  failures++; $display("wrong value %s exp %h got %h", n, x, y); end end
module tb_top;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [63:0] i_ro = '0;
  logic [63:0] i_xo = '0;
  logic req, done, err, busy, e;
  logic [1:0] op, src;
  logic [14:0] addr, a;
  logic [31:0] wdata, rdata, q, d;
  logic [14:0] nb [4] = '{15'h04FF, 15'h0500, 15'h05FF, 15'h0600};
  int failures = 0;
  int num_checks = 0;
  // Lead-in negedge, request edge, then one word written per cycle; done rises with the last write
  localparam int ERASE_CYC = 2 + flash_prot_pkg::BLOCK_WORDS;
  time t0;
  flash_block_protection u_flash_block_protection (.i_sys_clk, .i_rst,
    .i_req(req), .i_op(op), .i_src(src), .i_addr(addr), .i_wdata(wdata),
    .i_ro, .i_xo, .o_done(done), .o_rdata(rdata), .o_err(err),
    .o_busy(busy));
  flash_master_model u_flash_master_model (.i_sys_clk, .i_done(done),
    .i_err(err), .i_rdata(rdata), .o_req(req), .o_op(op), .o_src(src),
    .o_addr(addr), .o_wdata(wdata));
  always #10 i_sys_clk = ~i_sys_clk;
  // Address-derived pattern, so each word is told apart from its block
  function automatic logic [31:0] exp_word(logic [14:0] x);
    return {~x, x, 2'h3};
  endfunction
  task automatic print_verdict();
    if (failures == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge i_sys_clk);
    failures++;
    print_verdict();
  end
  initial begin
    void'($urandom(32'hB193));
    repeat (2) @(posedge i_sys_clk);
    @(negedge i_sys_clk) i_rst = 1'b0;
    // Random words read back by every master kind
    for (int k = 0; k < 24; k++) begin
      a = 15'($urandom);
      d = $urandom;
      u_flash_master_model.xfer(2'h1, 2'h1, a, d, q, e);
      t0 = $time;
      u_flash_master_model.xfer(2'h0, 2'(k % 3), a, 32'h0, q, e);
      `CHK("read", d, q)
      `CHK("read cycles", 2, ($time - t0) / 20)
    end
    foreach (nb[i]) u_flash_master_model.xfer(2'h1, 2'h1, nb[i],
      exp_word(nb[i]), q, e);
    t0 = $time;
    u_flash_master_model.xfer(2'h2, 2'h1, 15'h0500, 32'h0, q, e);
    `CHK("erase cycles", ERASE_CYC, ($time - t0) / 20)
    `CHK("busy", 1'b0, busy)
    // Neighbour blocks must survive the sweep
    foreach (nb[i]) begin
      u_flash_master_model.xfer(2'h0, 2'h2, nb[i], 32'h0, q, e);
      `CHK("erase", nb[i][14:8] == 7'h05 ? '1 : exp_word(nb[i]), q)
    end
    // Read-only then exec-only on unit 2
    for (int m = 0; m < 2; m++) begin
      i_ro[2] = (m == 0);
      i_xo[2] = (m == 1);
      for (int o = 1; o < 3; o++) begin
        u_flash_master_model.xfer(2'(o), 2'h1, 15'h04FF, 32'h0, q, e);
        `CHK("refuse", 1'b1, e)
      end
      for (int s = 0; s < 3; s++) begin
        u_flash_master_model.xfer(2'h0, 2'(s), 15'h04FF, 32'h0, q, e);
        `CHK("deny", m == 1 && s != 0, e)
        `CHK("data", m == 1 && s != 0 ? '0 : exp_word(15'h04FF), q)
      end
    end
    // Undefined op code completes quietly and writes nothing
    u_flash_master_model.xfer(2'h3, 2'h1, 15'h04FF, 32'h0, q, e);
    `CHK("undef err", 1'b0, e)
    u_flash_master_model.xfer(2'h3, 2'h1, nb[3], 32'h0, q, e);
    `CHK("undef err", 1'b0, e)
    u_flash_master_model.xfer(2'h0, 2'h0, nb[3], 32'h0, q, e);
    `CHK("undef data", exp_word(nb[3]), q)
    print_verdict();
  end
endmodule
